// ---- hw/afc_alert_ctrl.sv ----
// Alert pin, status flags and register file of the current and power monitor
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RULE1) With the power limit enable set, a power result above the alert limit raises the alert.
// (RULE2) With the ready alert enable set, a set conversion-ready flag raises the alert.
// (RULE3) Only one limit function drives the alert, though conversion-ready may share the pin.
// (RULE4) The alert function flag shows that the limit function, not ready, caused the alert.
// (RULE5) In latched mode the alert function flag clears only on a read of the mask register.
// (RULE6) In transparent mode that flag clears after the next conversion without an alert.
// (RULE7) The ready flag sets once all conversions, averaging and products of a cycle are done.
// (RULE8) In single-shot mode a configuration write clears the ready flag unless it powers down.
// (RULE9) In single-shot mode a read of the mask register also clears the ready flag.
// (RULE10) An arithmetic overflow sets the math overflow flag.
// (RULE11) Polarity 1 makes the open-collector alert active high, 0 active low, low by default.
// (RULE12) Latch enable 1 latches the alert, 0 is transparent, transparent by default.
// (RULE13) In transparent mode the pin and flags go idle once the fault has gone.
// (RULE14) In latched mode the pin and flags stay active until the mask register is read.
// (RULE15) With several limit enables set, the most significant one alone is compared.
// (RULE16) The selected result is compared against the separate alert limit register.
// (RULE17) Read clears act once the serial read of the mask register has returned its word.
module afc_alert_ctrl
  import afc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // Serial register link
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Open-collector alert pin
  output logic             alert_o,
  output logic             alert_oe_o,
  // Conversion engine
  input  wire afc_meas_t   meas_i,
  output logic [15:0]      cfg_o,
  output logic [15:0]      cal_o
);

  ////////////////////////////////////////////////////////////////////////
  // Single-shot modes have the continuous bit clear and a nonzero select
  function automatic logic is_idle_mode(input logic [15:0] cfg);
    return cfg[MODE_SEL_MSB:0] == 2'h0;
  endfunction

  function automatic logic is_single_shot(input logic [15:0] cfg);
    return !cfg[MODE_CONT_BIT] && !is_idle_mode(cfg);
  endfunction

  // Priority compare of the selected result against the limit
  function automatic logic limit_crossed(input logic [15:0] en, input afc_meas_t m,
                                         input logic [15:0] lim);
    logic hit;
    hit = 1'b0;
    if (en[BIT_SHUNT_OVER]) begin
      hit = $signed(m.shunt) > $signed(lim);
    end else if (en[BIT_SHUNT_UNDER]) begin
      hit = $signed(m.shunt) < $signed(lim);
    end else if (en[BIT_BUS_OVER]) begin
      hit = m.bus > lim;
    end else if (en[BIT_BUS_UNDER]) begin
      hit = m.bus < lim;
    end else if (en[BIT_POWER_OVER]) begin
      hit = m.power > lim;
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  afc_reg_req_t req;
  logic [15:0]  rdata;
  logic [15:0]  cfg, next_cfg;
  logic [15:0]  cal, next_cal;
  logic [15:0]  limit, next_limit;
  logic [5:0]   alert_en, next_alert_en;
  logic         alert_polarity, next_alert_polarity;
  logic         alert_latch_en, next_alert_latch_en;
  logic         alert_function_flag, next_alert_function_flag;
  logic         conv_ready_flag, next_conv_ready_flag;
  logic         math_overflow_flag, next_math_overflow_flag;
  logic         alert_oe, next_alert_oe;
  logic [15:0]  en_word;
  logic         power_over_limit_en, conv_ready_alert_en;
  logic         any_limit_en, limit_hit, read_mask, write_cfg, alert_act;

  afc_link_target u_link (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_oe_o  (sda_oe_o),
    .rdata_i   (rdata),
    .req_o     (req)
  );

  assign en_word             = {alert_en, 10'h000};
  assign power_over_limit_en = en_word[BIT_POWER_OVER];
  assign conv_ready_alert_en = en_word[BIT_CONV_READY];
  assign any_limit_en        = |en_word[BIT_SHUNT_OVER:BIT_POWER_OVER];
  assign read_mask           = req.rd_done && (req.ptr == PTR_MASK);
  assign write_cfg           = req.wr && (req.ptr == PTR_CONFIG);
  // RULE15 highest enable wins
  // RULE16 compare against limit
  assign limit_hit           = limit_crossed(en_word, meas_i, limit);

  ////////////////////////////////////////////////////////////////////////
  // Read data; results come straight from the engine so they read at any time
  always_comb begin
    rdata = 16'h0000;
    unique case (req.ptr)
      PTR_CONFIG:  rdata = cfg;
      PTR_SHUNT:   rdata = meas_i.shunt;
      PTR_BUS:     rdata = meas_i.bus;
      PTR_POWER:   rdata = meas_i.power;
      PTR_CURRENT: rdata = meas_i.current;
      PTR_CALIB:   rdata = cal;
      PTR_MASK: begin
        rdata                = en_word;
        rdata[BIT_AFF]       = alert_function_flag;
        rdata[BIT_CONV_READY_FLAG]      = conv_ready_flag;
        rdata[BIT_OVF]       = math_overflow_flag;
        rdata[BIT_ALERT_POLARITY]      = alert_polarity;
        rdata[BIT_LEN]       = alert_latch_en;
      end
      PTR_LIMIT:   rdata = limit;
      default:     rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable fields
  always_comb begin
    next_cfg            = cfg;
    next_cal            = cal;
    next_limit          = limit;
    next_alert_en       = alert_en;
    next_alert_polarity = alert_polarity;
    next_alert_latch_en = alert_latch_en;
    if (req.wr) begin
      unique case (req.ptr)
        PTR_CONFIG: next_cfg = req.wdata;
        PTR_CALIB:  next_cal = req.wdata;
        PTR_LIMIT:  next_limit = req.wdata;
        PTR_MASK: begin
          next_alert_en       = req.wdata[BIT_SHUNT_OVER:BIT_CONV_READY];
          next_alert_polarity = req.wdata[BIT_ALERT_POLARITY];
          next_alert_latch_en = req.wdata[BIT_LEN];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags; a conversion in the clearing cycle wins over the clear
  always_comb begin
    next_alert_function_flag = alert_function_flag;
    next_conv_ready_flag     = conv_ready_flag;
    next_math_overflow_flag  = math_overflow_flag;
    if (meas_i.conv_done) begin
      // RULE4 limit source flag
      // RULE6 transparent conversion update
      next_alert_function_flag = alert_latch_en ? (alert_function_flag | limit_hit) : limit_hit;
    end else if (alert_latch_en && read_mask) begin
      // RULE5 latched read clear
      next_alert_function_flag = 1'b0;
    end
    if (meas_i.conv_done) begin
      // RULE7 ready after cycle
      next_conv_ready_flag = 1'b1;
    end else if (read_mask || (is_single_shot(cfg) && write_cfg && !is_idle_mode(req.wdata))) begin
      // RULE8 RULE9 ready flag clear
      next_conv_ready_flag = 1'b0;
    end
    if (meas_i.conv_done) begin
      // RULE10 overflow flag set
      next_math_overflow_flag = alert_latch_en ? (math_overflow_flag | meas_i.math_ovf)
                                               : meas_i.math_ovf;
    end else if (alert_latch_en && read_mask) begin
      next_math_overflow_flag = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The pin follows the flags, so latching the flags latches the pin
  always_comb begin
    // RULE1 RULE3 pin sources
    // RULE2 ready drives pin
    // RULE13 RULE14 pin tracks flags
    alert_act     = (any_limit_en & alert_function_flag) | (conv_ready_alert_en & conv_ready_flag);
    // RULE11 open-collector sense
    next_alert_oe = alert_act ^ alert_polarity;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg                 <= CONFIG_RESET;
      cal                 <= CALIB_RESET;
      limit               <= LIMIT_RESET;
      alert_en            <= MASK_RESET[BIT_SHUNT_OVER:BIT_CONV_READY];
      // RULE12 transparent by default
      alert_polarity      <= MASK_RESET[BIT_ALERT_POLARITY];
      alert_latch_en      <= MASK_RESET[BIT_LEN];
      alert_function_flag <= MASK_RESET[BIT_AFF];
      conv_ready_flag     <= MASK_RESET[BIT_CONV_READY_FLAG];
      math_overflow_flag  <= MASK_RESET[BIT_OVF];
      alert_oe            <= 1'b0;
    end else begin
      cfg                 <= next_cfg;
      cal                 <= next_cal;
      limit               <= next_limit;
      alert_en            <= next_alert_en;
      alert_polarity      <= next_alert_polarity;
      alert_latch_en      <= next_alert_latch_en;
      alert_function_flag <= next_alert_function_flag;
      conv_ready_flag     <= next_conv_ready_flag;
      math_overflow_flag  <= next_math_overflow_flag;
      alert_oe            <= next_alert_oe;
    end
  end

  assign alert_o    = 1'b0;
  assign alert_oe_o = alert_oe;
  assign sda_o      = 1'b0;
  assign cfg_o      = cfg;
  assign cal_o      = cal;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  a_power_limit_alert: // RULE1
    assert property (meas_i.conv_done && power_over_limit_en && en_word[15:12] == 4'h0
                     && meas_i.power > limit |=> alert_function_flag)
    else $error("power above limit did not set the function flag");

  a_ready_drives_pin: // RULE2
    assert property (meas_i.conv_done && conv_ready_alert_en && !alert_polarity && !req.wr
                     |-> ##2 alert_oe_o)
    else $error("conversion-ready alert did not pull the pin");

  a_latched_flag_hold: // RULE5
    assert property (alert_latch_en && alert_function_flag && !read_mask |=> alert_function_flag)
    else $error("latched function flag dropped without a read");

  a_transp_flag_clear: // RULE6
    assert property (!alert_latch_en && meas_i.conv_done && !limit_hit |=> !alert_function_flag)
    else $error("transparent function flag not cleared by a clean conversion");

  a_ready_flag_set: // RULE7
    assert property (meas_i.conv_done |=> conv_ready_flag)
    else $error("ready flag not set after conversion");

  a_ready_write_clear: // RULE8
    assert property (is_single_shot(cfg) && write_cfg && !is_idle_mode(req.wdata)
                     && !meas_i.conv_done |=> !conv_ready_flag)
    else $error("configuration write did not clear the ready flag");

  a_ready_read_clear: // RULE9
    assert property (read_mask && !meas_i.conv_done |=> !conv_ready_flag)
    else $error("mask read did not clear the ready flag");

  a_overflow_set: // RULE10
    assert property (meas_i.conv_done && meas_i.math_ovf |=> math_overflow_flag)
    else $error("overflow flag not set");

  a_pin_polarity: // RULE11
    assert property ($stable(alert_polarity) && alert_act |=> alert_oe_o == !alert_polarity)
    else $error("alert pin sense does not follow polarity");

  a_latched_pin_hold: // RULE14
    assert property (alert_latch_en && $past(alert_latch_en) && alert_oe_o && !alert_polarity
                     && !$past(read_mask) && !$past(req.wr) |=> alert_oe_o)
    else $error("latched alert pin released without a read");

  a_priority_select: // RULE15
    assert property (meas_i.conv_done && en_word[BIT_SHUNT_OVER] && alert_latch_en == 1'b0
                     && $signed(meas_i.shunt) <= $signed(limit) |=> !alert_function_flag)
    else $error("lower priority enable compared while shunt over is set");

  c_ready_alert:
    cover property (meas_i.conv_done && conv_ready_alert_en ##2 alert_oe_o);
  c_latched_read_clear:
    cover property (alert_latch_en && alert_function_flag && read_mask ##1 !alert_function_flag);
  c_mask_write:
    cover property (req.wr && req.ptr == PTR_MASK);
  c_power_alert:
    cover property (meas_i.conv_done && power_over_limit_en && limit_hit);

endmodule

`default_nettype wire

// ---- hw/afc_link_target.sv ----
// Serial register link target of the alert and flag controller
`timescale 1ns/10ps
`default_nettype none

module afc_link_target
  import afc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // Serial pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_oe_o,
  // Register side
  input  wire logic [15:0] rdata_i,
  output afc_reg_req_t     req_o
);

  logic            scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic            scl_rise, scl_fall, start_ev, stop_ev;
  afc_link_state_t state, next_state;
  logic [3:0]      bit_cnt, next_bit_cnt;
  logic [7:0]      shreg, next_shreg;
  logic [7:0]      hi_byte, next_hi_byte;
  logic [7:0]      ptr, next_ptr;
  logic [15:0]     txw, next_txw;
  logic [1:0]      byte_idx, next_byte_idx;
  logic            rw, next_rw;
  logic            sda_oe, next_sda_oe;
  afc_reg_req_t    next_req;

  ////////////////////////////////////////////////////////////////////////
  // Idle bus is high, so the synchronisers start high
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_hi_byte  = hi_byte;
    next_ptr      = ptr;
    next_txw      = txw;
    next_byte_idx = byte_idx;
    next_rw       = rw;
    next_sda_oe   = sda_oe;
    next_req      = '0;
    next_req.ptr  = ptr;
    next_req.wdata = req_o.wdata;
    if (start_ev) begin
      next_state    = ST_ADDR;
      next_bit_cnt  = 4'h0;
      next_byte_idx = 2'h0;
      next_sda_oe   = 1'b0;
    end else if (stop_ev) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: ;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_state   = ST_ACK;
            next_sda_oe  = 1'b1;
            if (state == ST_ADDR) begin
              next_rw = shreg[0];
              if (shreg[7:1] != LINK_ADDR) begin
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
              end
            end else begin
              unique case (byte_idx)
                2'h0: next_ptr = shreg;
                2'h1: next_hi_byte = shreg;
                default: begin
                  next_req.wr    = 1'b1;
                  next_req.wdata = {hi_byte, shreg};
                end
              endcase
              next_byte_idx = (byte_idx == 2'h2) ? 2'h1 : 2'(byte_idx + 2'h1);
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_state  = ST_TX;
              next_txw    = rdata_i;
              next_sda_oe = ~rdata_i[15];
            end else begin
              next_state  = ST_RX;
              next_sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end else if (scl_fall) begin
            next_txw = {txw[14:0], 1'b0};
            if (bit_cnt == BITS_PER_BYTE) begin
              next_state    = ST_MACK;
              next_bit_cnt  = 4'h0;
              next_sda_oe   = 1'b0;
              next_byte_idx = {1'b0, ~byte_idx[0]};
              // RULE17 word fully returned
              next_req.rd_done = byte_idx[0];
            end else begin
              next_sda_oe = ~txw[14];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            next_state = ST_TX;
            if (byte_idx[0]) begin
              next_sda_oe = ~txw[15];
            end else begin
              next_txw    = rdata_i;
              next_sda_oe = ~rdata_i[15];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      hi_byte  <= 8'h00;
      ptr      <= 8'h00;
      txw      <= 16'h0000;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      req_o    <= '0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      hi_byte  <= next_hi_byte;
      ptr      <= next_ptr;
      txw      <= next_txw;
      byte_idx <= next_byte_idx;
      rw       <= next_rw;
      sda_oe   <= next_sda_oe;
      req_o    <= next_req;
    end
  end

  assign sda_oe_o = sda_oe;

endmodule

`default_nettype wire

// ---- hw/afc_pkg.sv ----
// Shared constants and types of the alert and flag controller
package afc_pkg;

  // Register pointers
  localparam logic [7:0] PTR_CONFIG  = 8'h00;
  localparam logic [7:0] PTR_SHUNT   = 8'h01;
  localparam logic [7:0] PTR_BUS     = 8'h02;
  localparam logic [7:0] PTR_POWER   = 8'h03;
  localparam logic [7:0] PTR_CURRENT = 8'h04;
  localparam logic [7:0] PTR_CALIB   = 8'h05;
  localparam logic [7:0] PTR_MASK    = 8'h06;
  localparam logic [7:0] PTR_LIMIT   = 8'h07;

  // Field positions of alert_mask_enable_status
  localparam int unsigned BIT_SHUNT_OVER  = 15;
  localparam int unsigned BIT_SHUNT_UNDER = 14;
  localparam int unsigned BIT_BUS_OVER    = 13;
  localparam int unsigned BIT_BUS_UNDER   = 12;
  localparam int unsigned BIT_POWER_OVER  = 11;
  localparam int unsigned BIT_CONV_READY  = 10;
  localparam int unsigned BIT_AFF         = 4;
  localparam int unsigned BIT_CONV_READY_FLAG        = 3;
  localparam int unsigned BIT_OVF         = 2;
  localparam int unsigned BIT_ALERT_POLARITY        = 1;
  localparam int unsigned BIT_LEN         = 0;

  // Operating mode field of the configuration word
  localparam int unsigned MODE_CONT_BIT = 2;
  localparam int unsigned MODE_SEL_MSB  = 1;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0007;
  localparam logic [15:0] CALIB_RESET  = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;

  // Serial target address, arbitrary value
  localparam logic [6:0] LINK_ADDR = 7'h45;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Register access from the serial link
  typedef struct packed {
    logic        wr;
    logic        rd_done;
    logic [7:0]  ptr;
    logic [15:0] wdata;
  } afc_reg_req_t;

  // Results from the conversion engine
  typedef struct packed {
    logic        conv_done;
    logic        math_ovf;
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
    logic [15:0] current;
  } afc_meas_t;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK
  } afc_link_state_t;

endpackage

// ---- tb/afc_alert_ctrl_tb.sv ----
// Self-checking bench for the alert and flag controller
`timescale 1ns/10ps
`default_nettype none

module afc_alert_ctrl_tb
  import afc_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        scl;
  logic        h_oe;
  logic        sda_oe;
  logic        a_oe;
  afc_meas_t   meas;
  logic [15:0] cfg;
  logic [15:0] cal;
  logic        a_o;
  logic        s_o;
  logic [15:0] rw;
  int          fails;
  int          samples_checked;
  wire logic   sda;

  // Open-drain wire with pull-up
  assign sda = !(h_oe | sda_oe);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  afc_alert_ctrl i_afc_alert_ctrl (.clk_sys_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda),
    .sda_o(s_o), .sda_oe_o(sda_oe), .alert_o(a_o), .alert_oe_o(a_oe), .meas_i(meas), .cfg_o(cfg), .cal_o(cal));
  afc_host_model i_afc_host_model (.clk_sys_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input logic e);
    samples_checked++;
    if (a_oe !== e) begin
      fails++;
      $display("unexpected alert drive: expected %b seen %b", e, a_oe);
    end
  endtask

  task automatic rdchk(input logic [15:0] e);
    i_afc_host_model.rd(PTR_MASK, rw);
    chk16("mask register", e, rw);
  endtask

  // One conversion result, then time for flags and pin to follow
  task automatic conv(input logic [15:0] s, input logic [15:0] p, input logic o);
    meas.shunt = s;
    meas.power = p;
    meas.math_ovf = o;
    meas.conv_done = 1'b1;
    @(posedge clk);
    #1;
    meas.conv_done = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    meas = '0;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk1(1'b0);
    chk16("config", 16'h0007, cfg);
    chk16("pin levels", 16'h0000, {14'h0000, a_o, s_o});
    rdchk(16'h0000);
    // Active-high sense idles with the pin pulled low
    i_afc_host_model.wr(PTR_MASK, 16'h0002);
    chk1(1'b1);
    // Latched power limit; equal to the limit is no fault
    i_afc_host_model.wr(PTR_LIMIT, 16'h1000);
    i_afc_host_model.wr(PTR_CALIB, 16'h1234);
    chk16("calibration", 16'h1234, cal);
    i_afc_host_model.wr(PTR_MASK, 16'h0801);
    conv(16'h0000, 16'h1001, 1'b0);
    chk1(1'b1);
    conv(16'h0000, 16'h1000, 1'b0);
    chk1(1'b1);
    rdchk(16'h0819);
    chk1(1'b0);
    rdchk(16'h0801);
    // Transparent mode follows each conversion
    i_afc_host_model.wr(PTR_MASK, 16'h0800);
    conv(16'h0000, 16'hFFFF, 1'b0);
    chk1(1'b1);
    conv(16'h0000, 16'h1000, 1'b0);
    chk1(1'b0);
    rdchk(16'h0808);
    // Single-shot conversion ready
    i_afc_host_model.wr(PTR_CONFIG, 16'h0001);
    i_afc_host_model.wr(PTR_MASK, 16'h0400);
    chk1(1'b0);
    conv(16'h0000, 16'hFFFF, 1'b1);
    chk1(1'b1);
    rdchk(16'h040C);
    chk1(1'b0);
    // Clearing depends on whether the written mode powers down
    conv(16'h0000, 16'h0000, 1'b0);
    i_afc_host_model.wr(PTR_CONFIG, 16'h0002);
    chk1(1'b0);
    conv(16'h0000, 16'h0000, 1'b0);
    i_afc_host_model.wr(PTR_CONFIG, 16'h0000);
    chk1(1'b1);
    chk16("config", 16'h0000, cfg);
    // Shunt enable outranks power enable
    i_afc_host_model.wr(PTR_MASK, 16'h8800);
    conv(16'h0000, 16'hFFFF, 1'b0);
    chk1(1'b0);
    conv(16'h1001, 16'h0000, 1'b0);
    chk1(1'b1);
    give_verdict;
  end
endmodule

`default_nettype wire

// ---- tb/afc_host_model.sv ----
// Serial host model that writes and reads device registers
`timescale 1ns/10ps
`default_nettype none

module afc_host_model
  import afc_pkg::*;
(
  // Clock and pins
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  // Bus idles released, so the pull-up shows high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One bit slot, SCL low 4 clk then high 4 clk, read mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = !b;
    hc(4);
    scl_o = 1'b1;
    hc(2);
    r = sda_i;
    hc(2);
    scl_o = 1'b0;
  endtask

  // Sending 1s releases the line so the device can answer
  task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] r);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], x);
      r[i] = x;
    end
    bit_io(ack, x);
  endtask

  task automatic start;
    sda_oe_o = 1'b1;
    hc(4);
    scl_o = 1'b0;
  endtask

  task automatic stop;
    sda_oe_o = 1'b1;
    hc(4);
    scl_o = 1'b1;
    hc(4);
    sda_oe_o = 1'b0;
    hc(4);
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] r;
    start;
    byte_io({LINK_ADDR, 1'b0}, 1'b1, r);
    byte_io(p, 1'b1, r);
    byte_io(d[15:8], 1'b1, r);
    byte_io(d[7:0], 1'b1, r);
    stop;
  endtask

  // Pointer first, then a word read ended by a NACK
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [7:0] r;
    start;
    byte_io({LINK_ADDR, 1'b0}, 1'b1, r);
    byte_io(p, 1'b1, r);
    stop;
    start;
    byte_io({LINK_ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hFF, 1'b0, d[15:8]);
    byte_io(8'hFF, 1'b1, d[7:0]);
    stop;
  endtask
endmodule

`default_nettype wire
